// ---- bench/ssrc_board.sv ----
// board model: open-drain wake line and eeprom loader answer
`timescale 1ns/10ps
module ssrc_board (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic eeprom_load_start,
    output logic eeprom_load_done,
    input wire logic wake_pin_n_o,
    input wire logic wake_pin_n_oe,
    input wire logic wake_pull_low,
    output logic wake_pin_n_i,
    input wire logic [7:0] load_cycles
);
    logic [7:0] cnt_q;
    // pull-up: the line is high unless some party pulls it low
    assign wake_pin_n_i = !((wake_pin_n_oe && !wake_pin_n_o) || wake_pull_low);
    always @(posedge aclk) begin
        if (!aresetn) begin
            eeprom_load_done <= 1'h0;
            cnt_q <= 8'h00;
        end else if (eeprom_load_start) begin
            eeprom_load_done <= 1'h0;
            cnt_q <= load_cycles;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            eeprom_load_done <= (cnt_q == 8'h01);
        end
    end
endmodule // ssrc_board

// ---- bench/ssrc_checker.sv ----
// assertions on the strap and reset control ports
`timescale 1ns/10ps
module ssrc_checker
    import ssrc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aux_power_disable_n,
    input wire logic wake_pin_n_o,
    input wire logic wake_pin_n_oe,
    input wire logic core_reset_n,
    input wire logic link_fund_reset,
    input wire logic mgmt_bus_enable,
    input wire logic eeprom_load_start,
    input wire logic [6:0] eeprom_bus_addr,
    input wire logic master_bus_tick,
    input wire logic master_bus_slow,
    input wire logic aux_power_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [9:0] gap_q;
    logic seen_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || master_bus_tick) begin
            gap_q <= 10'h001;
        end else if (gap_q != 10'h3ff) begin
            gap_q <= gap_q + 10'h001;
        end
        if (!aresetn || !core_reset_n) begin
            seen_q <= 1'h0;
        end else if (master_bus_tick) begin
            seen_q <= 1'h1;
        end
    end
    property p_fund_core; link_fund_reset |-> !core_reset_n; endproperty
    a_fund_core: assert property (p_fund_core) else $error("core free during link reset");
    property p_run_bus; core_reset_n |-> mgmt_bus_enable && !link_fund_reset; endproperty
    a_run_bus: assert property (p_run_bus) else $error("run without buses");
    property p_eep_addr; eeprom_load_start |->
        eeprom_bus_addr[6:5] == SSRC_EEP_ADDR_HI && eeprom_bus_addr[0] == SSRC_EEP_ADDR_B0;
    endproperty
    a_eep_addr: assert property (p_eep_addr) else $error("bad eeprom address");
    property p_load_reset; eeprom_load_start |=> !eeprom_load_start && !core_reset_n; endproperty
    a_load_reset: assert property (p_load_reset) else $error("load not before run");
    property p_rate_fixed; core_reset_n && $past(core_reset_n) |-> $stable(master_bus_slow);
    endproperty
    a_rate_fixed: assert property (p_rate_fixed) else $error("bus rate changed in run");
    property p_tick_gap; master_bus_tick && seen_q |->
        gap_q == (master_bus_slow ? 10'h190 : 10'h064);
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("bus tick spacing wrong");
    property p_aux_off; (!aux_power_disable_n) [*6] |-> !aux_power_enable; endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux used while disabled");
    property p_wake_drive; wake_pin_n_oe |-> !wake_pin_n_o; endproperty
    a_wake_drive: assert property (p_wake_drive) else $error("wake driven high");
    c_load: cover property (eeprom_load_start);
    c_run: cover property ($rose(core_reset_n));
    c_wake: cover property ($rose(wake_pin_n_oe));
endmodule // ssrc_checker
bind ssrc_top ssrc_checker ssrc_checker_i (.aclk, .aresetn, .aux_power_disable_n, .wake_pin_n_o,
    .wake_pin_n_oe, .core_reset_n, .link_fund_reset, .mgmt_bus_enable, .eeprom_load_start,
    .eeprom_bus_addr, .master_bus_tick, .master_bus_slow, .aux_power_enable);

// ---- bench/ssrc_tb_top.sv ----
// bench for the strap and reset control block
`timescale 1ns/10ps
module ssrc_tb_top;
    import ssrc_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, wake_pull_low = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic fundamental_reset_n = 1'h0, reset_hold_strap = 1'h0, master_bus_slow_strap = 1'h0;
    logic common_clock_down_strap = 1'h0, common_clock_up_strap = 1'h0;
    logic aux_power_disable_n = 1'h1;
    logic [2:0] switch_mode_strap = 3'h0;
    logic [3:0] eeprom_addr_strap = 4'h0;
    logic wake_pin_n_i, wake_pin_n_o, wake_pin_n_oe, eeprom_load_done, core_reset_n;
    logic link_fund_reset, mgmt_bus_enable, eeprom_load_start, master_bus_tick;
    logic master_bus_slow, aux_power_enable, mode_reserved;
    logic [6:0] eeprom_bus_addr;
    int err_total = 0, num_checks = 0;
    always #12.5 aclk = ~aclk;
    ssrc_top ssrc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .fundamental_reset_n, .reset_hold_strap, .master_bus_slow_strap,
        .common_clock_down_strap, .common_clock_up_strap, .switch_mode_strap,
        .eeprom_addr_strap, .aux_power_disable_n, .wake_pin_n_i, .wake_pin_n_o, .wake_pin_n_oe,
        .eeprom_load_done, .core_reset_n, .link_fund_reset, .mgmt_bus_enable, .eeprom_load_start,
        .eeprom_bus_addr, .master_bus_tick, .master_bus_slow, .aux_power_enable, .mode_reserved);
    ssrc_board ssrc_board_i (.aclk, .aresetn, .eeprom_load_start, .eeprom_load_done,
        .wake_pin_n_o, .wake_pin_n_oe, .wake_pull_low, .wake_pin_n_i, .load_cycles(8'h14));
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task stop_test;
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        check("bresp", {30'h0, SSRC_RESP_OKAY}, {30'h0, s_axi_bresp});
    endtask
    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                input logic [31:0] exp, input logic [1:0] resp = SSRC_RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        check(what, exp, s_axi_rdata & m);
        check("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
    endtask
    task boot(input logic h, s, cd, cu, input logic [2:0] m, input logic [3:0] ea);
        @(posedge aclk);
        fundamental_reset_n <= 1'h0;
        reset_hold_strap <= h;
        master_bus_slow_strap <= s;
        common_clock_down_strap <= cd;
        common_clock_up_strap <= cu;
        switch_mode_strap <= m;
        eeprom_addr_strap <= ea;
        repeat (10) @(posedge aclk);
        fundamental_reset_n <= 1'h1;
    endtask
    task wait_core(input int lim);
        int n;
        for (n = 0; n < lim && core_reset_n !== 1'h1; n++) @(posedge aclk);
        check("core_reset_n", 32'h1, core_reset_n);
    endtask
    task automatic tick_gap(input logic [31:0] exp);
        int n;
        n = 0;
        do @(posedge aclk); while (master_bus_tick !== 1'h1);
        do begin
            @(posedge aclk);
            n++;
        end while (master_bus_tick !== 1'h1);
        check("tick gap", exp, n);
    endtask
    task scen_normal;
        boot(1'h0, 1'h0, 1'h1, 1'h0, SSRC_MODE_NORMAL, 4'h0);
        wait_core(200);
        check("link reset", 32'h0, link_fund_reset);
        rd_chk("status", SSRC_STATUS_OFS, 32'h3ff, 32'h004);
        rd_chk("up sclk", SSRC_UP_LSTS_OFS, 32'h1000, 32'h0);
        for (int p = 0; p < SSRC_DN_PORTS; p++) begin
            rd_chk("dn sclk", SSRC_DN_LSTS_OFS + 8'(4 * p), 32'h1000, 32'h1000);
        end
        axi_wr(SSRC_DN_LSTS_OFS, 32'h0);
        rd_chk("dn0 sclk", SSRC_DN_LSTS_OFS, 32'h1000, 32'h0);
        rd_chk("dn1 sclk", SSRC_DN_LSTS_OFS + 8'h04, 32'h1000, 32'h1000);
        axi_wr(SSRC_UP_LSTS_OFS, 32'h1000);
        rd_chk("up sclk", SSRC_UP_LSTS_OFS, 32'h1000, 32'h1000);
        tick_gap(32'h64);
        axi_wr(SSRC_BUSCFG_OFS, 32'h80);
        rd_chk("buscfg slow", SSRC_BUSCFG_OFS, 32'h80, 32'h0);
        master_bus_slow_strap <= 1'h1;
        repeat (10) @(posedge aclk);
        rd_chk("status slow", SSRC_STATUS_OFS, 32'h80, 32'h0);
        tick_gap(32'h64);
        rd_chk("unmapped", 8'h40, 32'hffffffff, 32'h0, SSRC_RESP_SLVERR);
    endtask
    task scen_wake;
        rd_chk("wake reset", SSRC_WAKE_OFS, 32'h3, SSRC_WAKE_RST);
        axi_wr(SSRC_WAKE_OFS, 32'h3);
        repeat (4) @(posedge aclk);
        check("wake oe", 32'h1, wake_pin_n_oe);
        check("wake out", 32'h0, wake_pin_n_o);
        rd_chk("wake drive", SSRC_WAKE_OFS, 32'h7, 32'h7);
        axi_wr(SSRC_WAKE_OFS, 32'h0);
        repeat (4) @(posedge aclk);
        check("wake oe", 32'h0, wake_pin_n_oe);
        rd_chk("wake idle", SSRC_WAKE_OFS, 32'h4, 32'h0);
        wake_pull_low <= 1'h1;
        repeat (6) @(posedge aclk);
        rd_chk("wake sense", SSRC_WAKE_OFS, 32'h4, 32'h4);
        wake_pull_low <= 1'h0;
    endtask
    task scen_hold;
        int n;
        boot(1'h1, 1'h1, 1'h0, 1'h1, SSRC_MODE_EEPROM, 4'ha);
        for (n = 0; n < 200 && eeprom_load_start !== 1'h1; n++) @(posedge aclk);
        check("load start", 32'h1, eeprom_load_start);
        check("eeprom addr", {25'h0, SSRC_EEP_ADDR_HI, 4'ha, SSRC_EEP_ADDR_B0}, eeprom_bus_addr);
        repeat (60) @(posedge aclk);
        check("held core", 32'h0, core_reset_n);
        check("bus enable", 32'h1, mgmt_bus_enable);
        rd_chk("hold state", SSRC_STATUS_OFS, 32'h87, 32'h83);
        rd_chk("hold bit", SSRC_SWCTL_OFS, 32'h1, 32'h1);
        rd_chk("up sclk", SSRC_UP_LSTS_OFS, 32'h1000, 32'h1000);
        rd_chk("dn1 sclk", SSRC_DN_LSTS_OFS + 8'h04, 32'h1000, 32'h0);
        axi_wr(SSRC_SWCTL_OFS, 32'h0);
        wait_core(20);
        tick_gap(32'h190);
    endtask
    task scen_reserved;
        aux_power_disable_n <= 1'h0;
        for (int m = 2; m < 8; m++) begin
            boot(1'h0, 1'h0, 1'h1, 1'h1, 3'(m), 4'h3);
            wait_core(200);
            check("mode reserved", 32'h1, mode_reserved);
        end
        check("aux enable", 32'h0, aux_power_enable);
        rd_chk("status", SSRC_STATUS_OFS, 32'h17f, 32'h17c);
        aux_power_disable_n <= 1'h1;
        repeat (10) @(posedge aclk);
        check("aux enable", 32'h1, aux_power_enable);
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        scen_normal;
        scen_wake;
        scen_hold;
        scen_reserved;
        stop_test;
    end
    // longest path is well under this span; a stuck handshake lands here
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        stop_test;
    end
endmodule // ssrc_tb_top

// ---- logic/ssrc_pkg.sv ----
// constants for the switch strap and reset control block
package ssrc_pkg;
    // register byte offsets
    localparam logic [7:0] SSRC_SWCTL_OFS = 8'h00;
    localparam logic [7:0] SSRC_STATUS_OFS = 8'h04;
    localparam logic [7:0] SSRC_UP_LSTS_OFS = 8'h08;
    localparam logic [7:0] SSRC_DN_LSTS_OFS = 8'h0c;
    localparam logic [7:0] SSRC_WAKE_OFS = 8'h1c;
    localparam logic [7:0] SSRC_BUSCFG_OFS = 8'h20;
    localparam int SSRC_DN_PORTS = 4;
    // field positions
    localparam int SSRC_HOLD_BIT = 0;
    localparam int SSRC_SCLK_BIT = 12;
    localparam int SSRC_WAKE_DIR_BIT = 0;
    localparam int SSRC_WAKE_ASSERT_BIT = 1;
    localparam int SSRC_WAKE_SENSE_BIT = 2;
    // switch mode encodings
    localparam logic [2:0] SSRC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] SSRC_MODE_EEPROM = 3'h1;
    // fixed parts of the serial eeprom bus address
    localparam logic [1:0] SSRC_EEP_ADDR_HI = 2'h2;
    localparam logic SSRC_EEP_ADDR_B0 = 1'b0;
    // reset values
    localparam logic [31:0] SSRC_WAKE_RST = 32'h0000_0000;
    // timing
    localparam int SSRC_CLK_PERIOD_NS = 25;
    localparam int SSRC_BUS_FAST_PERIOD_NS = 2500;
    localparam int SSRC_BUS_SLOW_PERIOD_NS = 10000;
    localparam int SSRC_RST_PROC_NS = 1000;
    localparam logic [8:0] SSRC_BUS_FAST_CYC = 9'(SSRC_BUS_FAST_PERIOD_NS / SSRC_CLK_PERIOD_NS);
    localparam logic [8:0] SSRC_BUS_SLOW_CYC = 9'(SSRC_BUS_SLOW_PERIOD_NS / SSRC_CLK_PERIOD_NS);
    localparam logic [7:0] SSRC_RST_PROC_CYC =
        8'((SSRC_RST_PROC_NS + SSRC_CLK_PERIOD_NS - 1) / SSRC_CLK_PERIOD_NS);
    // axi responses
    localparam logic [1:0] SSRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SSRC_RESP_SLVERR = 2'h2;
    // sequencer states
    typedef enum logic [2:0] {
        SSRC_ST_FUND_RST = 3'b000,
        SSRC_ST_RST_PROC = 3'b001,
        SSRC_ST_EEP_LOAD = 3'b010,
        SSRC_ST_HOLD = 3'b011,
        SSRC_ST_RUN = 3'b100
    } ssrc_state_e;
endpackage

// ---- logic/ssrc_top.sv ----
// strap capture, reset sequencing, wake pin and aux power control with axi4-lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Functional notes
// - downstream common-clock strap seeds every downstream slot clock bit; writable.
// - upstream common-clock strap seeds upstream slot clock bit; stays software writable.
// - slow strap gives master bus 100 kHz, otherwise 400 kHz.
// - no register write can change the master bus rate.
// - fundamental reset low resets internal logic and starts link fundamental reset.
// - hold strap at reset: finish reset procedure, stay in reset, buses stay active.
// - bus master clearing the hold bit releases the held reset into normal operation.
// - mode 0 normal, mode 1 eeprom load first, other codes reserved.
// - wake direction bit chooses whether the wake pin is sensed or driven.
// - while aux power disable is active the aux supply is not used.
// - eeprom load uses the bus address from the four eeprom address straps.
module ssrc_top
    import ssrc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fundamental_reset_n,
    input wire logic reset_hold_strap,
    input wire logic master_bus_slow_strap,
    input wire logic common_clock_down_strap,
    input wire logic common_clock_up_strap,
    input wire logic [2:0] switch_mode_strap,
    input wire logic [3:0] eeprom_addr_strap,
    input wire logic aux_power_disable_n,
    input wire logic wake_pin_n_i,
    output logic wake_pin_n_o,
    output logic wake_pin_n_oe,
    input wire logic eeprom_load_done,
    output logic core_reset_n,
    output logic link_fund_reset,
    output logic mgmt_bus_enable,
    output logic eeprom_load_start,
    output logic [6:0] eeprom_bus_addr,
    output logic master_bus_tick,
    output logic master_bus_slow,
    output logic aux_power_enable,
    output logic mode_reserved
);
    localparam int NSYNC = 14;
    // pin synchronisers: bit order matches the concatenation below
    logic [NSYNC-1:0] pins_raw, sync1_q, sync2_q, sync3_q, pins_q;
    logic fund_n_s, aux_dis_n_s, wake_n_s, hold_s, slow_s, ccd_s, ccu_s;
    logic [2:0] mode_s;
    logic [3:0] eaddr_s;
    // latched straps
    logic hold_strap_q, slow_strap_q;
    logic [2:0] mode_q;
    logic [3:0] eaddr_q;
    ssrc_state_e state_q;
    logic [7:0] proc_cnt_q;
    logic [8:0] div_cnt_q;
    // registers
    logic hold_bit_q, up_sclk_q;
    logic [SSRC_DN_PORTS-1:0] dn_sclk_q;
    logic [31:0] wake_ctl_q;
    // bus slave
    logic aw_full_q, w_full_q, do_write, wr_hit, rd_hit;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q, rd_data;
    logic [3:0] w_strb_q;
    // byte-lane merge of one bit at position pos
    function automatic logic wr_bit(input logic old_v, input logic [31:0] data,
                                    input logic [3:0] strb, input int pos);
        wr_bit = strb[pos/8] ? data[pos] : old_v;
    endfunction
    // index of a downstream link status register, or -1
    function automatic int dn_index(input logic [7:0] addr);
        dn_index = -1;
        for (int i = 0; i < SSRC_DN_PORTS; i++) begin
            if (addr == 8'(SSRC_DN_LSTS_OFS + 8'(4 * i))) begin
                dn_index = i;
            end
        end
    endfunction
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr == SSRC_SWCTL_OFS) || (addr == SSRC_STATUS_OFS) ||
                      (addr == SSRC_UP_LSTS_OFS) || (addr == SSRC_WAKE_OFS) ||
                      (addr == SSRC_BUSCFG_OFS) || (dn_index(addr) >= 0);
    endfunction
    assign pins_raw = {fundamental_reset_n, aux_power_disable_n, wake_pin_n_i,
                       reset_hold_strap, master_bus_slow_strap, common_clock_down_strap,
                       common_clock_up_strap, switch_mode_strap, eeprom_addr_strap};
    assign {fund_n_s, aux_dis_n_s, wake_n_s, hold_s, slow_s, ccd_s, ccu_s, mode_s,
            eaddr_s} = pins_q;
    always_ff @(posedge aclk) begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_q <= '0;
        end else begin
            for (int i = 0; i < NSYNC; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pins_q[i] <= sync3_q[i];
                end
            end
        end
    end
    // straps follow the pins only while fundamental reset is asserted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_strap_q <= 1'b0;
            slow_strap_q <= 1'b0;
            mode_q <= SSRC_MODE_NORMAL;
            eaddr_q <= 4'h0;
        end else if (!fund_n_s) begin
            hold_strap_q <= hold_s;
            slow_strap_q <= slow_s;
            mode_q <= mode_s;
            eaddr_q <= eaddr_s;
        end
    end
    // reset sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SSRC_ST_FUND_RST;
            proc_cnt_q <= 8'h00;
        end else if (!fund_n_s) begin
            state_q <= SSRC_ST_FUND_RST;
            proc_cnt_q <= 8'h00;
        end else begin
            unique case (state_q)
                SSRC_ST_FUND_RST: begin
                    state_q <= SSRC_ST_RST_PROC;
                    proc_cnt_q <= 8'h00;
                end
                SSRC_ST_RST_PROC: begin
                    proc_cnt_q <= proc_cnt_q + 8'h01;
                    if (proc_cnt_q == SSRC_RST_PROC_CYC - 8'h01) begin
                        if (mode_q == SSRC_MODE_EEPROM) begin
                            state_q <= SSRC_ST_EEP_LOAD;
                        end else if (hold_bit_q) begin
                            state_q <= SSRC_ST_HOLD;
                        end else begin
                            state_q <= SSRC_ST_RUN;
                        end
                    end
                end
                SSRC_ST_EEP_LOAD: begin
                    if (eeprom_load_done) begin
                        state_q <= hold_bit_q ? SSRC_ST_HOLD : SSRC_ST_RUN;
                    end
                end
                SSRC_ST_HOLD: begin
                    if (!hold_bit_q) begin
                        state_q <= SSRC_ST_RUN;
                    end
                end
                SSRC_ST_RUN: state_q <= SSRC_ST_RUN;
                default: begin
                    state_q <= SSRC_ST_FUND_RST;
                end
            endcase
        end
    end
    // core stays in reset through the hold state; links reset only until the procedure starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset_n <= 1'b0;
            link_fund_reset <= 1'b1;
            mgmt_bus_enable <= 1'b0;
            eeprom_load_start <= 1'b0;
        end else begin
            core_reset_n <= (state_q == SSRC_ST_RUN) && fund_n_s;
            link_fund_reset <= !fund_n_s || (state_q == SSRC_ST_FUND_RST);
            mgmt_bus_enable <= fund_n_s && (state_q != SSRC_ST_FUND_RST);
            eeprom_load_start <= fund_n_s && (state_q == SSRC_ST_RST_PROC) &&
                                 (proc_cnt_q == SSRC_RST_PROC_CYC - 8'h01) &&
                                 (mode_q == SSRC_MODE_EEPROM);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reserved <= 1'b0;
            eeprom_bus_addr <= 7'h00;
        end else begin
            mode_reserved <= (mode_q != SSRC_MODE_NORMAL) &&
                             (mode_q != SSRC_MODE_EEPROM);
            eeprom_bus_addr <= {SSRC_EEP_ADDR_HI, eaddr_q, SSRC_EEP_ADDR_B0};
        end
    end
    // bus rate divider; rate comes only from the latched strap, no register feeds it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= 9'h000;
            master_bus_tick <= 1'b0;
            master_bus_slow <= 1'b0;
        end else begin
            master_bus_slow <= slow_strap_q;
            if (div_cnt_q >= (slow_strap_q ? SSRC_BUS_SLOW_CYC : SSRC_BUS_FAST_CYC) - 9'h001) begin
                div_cnt_q <= 9'h000;
                master_bus_tick <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 9'h001;
                master_bus_tick <= 1'b0;
            end
        end
    end
    // aux power and wake pin; open drain so only ever drives low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_power_enable <= 1'b0;
            wake_pin_n_o <= 1'b0;
            wake_pin_n_oe <= 1'b0;
        end else begin
            aux_power_enable <= aux_dis_n_s;
            wake_pin_n_o <= 1'b0;
            wake_pin_n_oe <= wake_ctl_q[SSRC_WAKE_DIR_BIT] &&
                             wake_ctl_q[SSRC_WAKE_ASSERT_BIT];
        end
    end
    // axi write channels, taken in either order
    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_hit = addr_mapped(aw_addr_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SSRC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_full_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? SSRC_RESP_OKAY : SSRC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // switch control hold bit: seeded from the strap during fundamental reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_bit_q <= 1'b0;
        end else if (!fund_n_s) begin
            hold_bit_q <= hold_s;
        end else if (do_write && aw_addr_q == SSRC_SWCTL_OFS) begin
            hold_bit_q <= wr_bit(hold_bit_q, w_data_q, w_strb_q, SSRC_HOLD_BIT);
        end
    end
    // slot clock bits reload from straps on every fundamental reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_sclk_q <= 1'b0;
            dn_sclk_q <= '0;
        end else if (!fund_n_s) begin
            up_sclk_q <= ccu_s;
            dn_sclk_q <= {SSRC_DN_PORTS{ccd_s}};
        end else if (do_write) begin
            if (aw_addr_q == SSRC_UP_LSTS_OFS) begin
                up_sclk_q <= wr_bit(up_sclk_q, w_data_q, w_strb_q, SSRC_SCLK_BIT);
            end
            for (int i = 0; i < SSRC_DN_PORTS; i++) begin
                if (dn_index(aw_addr_q) == i) begin
                    dn_sclk_q[i] <= wr_bit(dn_sclk_q[i], w_data_q, w_strb_q,
                                           SSRC_SCLK_BIT);
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_ctl_q <= SSRC_WAKE_RST;
        end else if (do_write && aw_addr_q == SSRC_WAKE_OFS) begin
            for (int b = SSRC_WAKE_DIR_BIT; b <= SSRC_WAKE_ASSERT_BIT; b++) begin
                wake_ctl_q[b] <= wr_bit(wake_ctl_q[b], w_data_q, w_strb_q, b);
            end
        end
    end
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = addr_mapped({s_axi_araddr[7:2], 2'b00});
        unique case ({s_axi_araddr[7:2], 2'b00})
            SSRC_SWCTL_OFS: rd_data[SSRC_HOLD_BIT] = hold_bit_q;
            SSRC_STATUS_OFS: rd_data[9:0] = {!fund_n_s, !aux_dis_n_s, slow_strap_q,
                                             mode_reserved, mode_q, state_q};
            SSRC_UP_LSTS_OFS: rd_data[SSRC_SCLK_BIT] = up_sclk_q;
            SSRC_WAKE_OFS: begin
                rd_data[1:0] = wake_ctl_q[1:0];
                rd_data[SSRC_WAKE_SENSE_BIT] = !wake_n_s;
            end
            SSRC_BUSCFG_OFS: rd_data[7:0] = {slow_strap_q, eeprom_bus_addr};
            default: begin
                for (int i = 0; i < SSRC_DN_PORTS; i++) begin
                    if (dn_index({s_axi_araddr[7:2], 2'b00}) == i) begin
                        rd_data[SSRC_SCLK_BIT] = dn_sclk_q[i];
                    end
                end
            end
        endcase
    end
    // read channel: one outstanding read, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SSRC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_data : 32'h0000_0000;
                s_axi_rresp <= rd_hit ? SSRC_RESP_OKAY : SSRC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // ssrc_top
